// ==== design/switch_global_id_start_control.sv ====
// global identity, start-up and control zero register bank
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
// Behaviour
// - manual strap modes start when start bit set
// - manual modes stay stopped while start bit clear
// - both straps low: read eeprom, start automatically
// - no eeprom: keep strap and default values
// - eeprom loads only if family byte and device code match
// - read-only family, device and revision fields
// - control bit 7 selects alternative back-off
// - control bit 3 forwards pause frames
// - link loss triggers fast age when enabled
// - after fast cycle, normal period resumes
// - any port unplugged ages out all addresses
module switch_global_id_start_control #(
  parameter int         NORMAL_AGE_US = switch_gid_pkg::NORMAL_AGE_US,
  // arbitrary identity values
  parameter logic [7:0] FAMILY_CODE   = 8'h5A,
  parameter logic [3:0] DEVICE_CODE   = 4'h3,
  parameter logic [2:0] REVISION      = 3'h1
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // register port
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  // strap pins
  input  wire logic                    boot_mode_strap_high,
  input  wire logic                    boot_mode_strap_low,
  // eeprom byte reader
  output logic                         ee_rd_req,
  output logic      [7:0]              ee_rd_addr,
  input  wire switch_gid_pkg::ee_rsp_s ee_rsp,
  // port link status
  input  wire logic [2:0]              port_link_up,
  // switch engine controls
  output logic                         switch_running,
  output logic                         new_backoff_en,
  output logic                         pass_pause_en,
  output logic                         age_tick,
  output logic                         fast_age_active,
  output logic                         flush_all
);

  logic [1:0]            strap;
  switch_gid_pkg::boot_e boot_r;
  logic [3:0]            settle_r;
  logic                  ee_pend_r;
  logic                  ee_req_r;
  logic [7:0]            ee_addr_r;
  logic                  ee_match_r;
  logic                  ee_start_r;
  logic                  auto_mode_r;
  logic                  ee_reading;
  logic                  ee_answer;
  logic                  ee_load;
  logic                  start_r;
  switch_gid_pkg::gc0_s  gc0_r;
  logic                  running_r;
  logic [7:0]            rdata_r;
  logic                  backoff_r;
  logic                  pause_r;
  logic [2:0]            link_d_r;
  logic                  link_fall;
  logic                  flush_r;
  logic                  fast_req;
  logic                  wr_id;
  logic                  wr_gc0;

  strap_sync u_strap (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .pin_in     ({boot_mode_strap_high, boot_mode_strap_low}),
    .pin_stable (strap)
  );

  assign ee_reading = (boot_r == switch_gid_pkg::BOOT_RD0) ||
                      (boot_r == switch_gid_pkg::BOOT_RD1) ||
                      (boot_r == switch_gid_pkg::BOOT_RD2);
  assign ee_answer  = ee_reading && ee_pend_r && ee_rsp.done;
  assign ee_load    = ee_answer && !ee_rsp.absent && ee_match_r &&
                      (boot_r == switch_gid_pkg::BOOT_RD2);
  assign wr_id      = reg_wr && (reg_addr == switch_gid_pkg::REG_ID_START);
  assign wr_gc0     = reg_wr && (reg_addr == switch_gid_pkg::REG_GCTRL0);

  // start-up sequencer
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_r      <= switch_gid_pkg::BOOT_STRAP;
      settle_r    <= '0;
      ee_pend_r   <= 1'b0;
      ee_req_r    <= 1'b0;
      ee_addr_r   <= switch_gid_pkg::ZERO_BYTE;
      ee_match_r  <= 1'b0;
      ee_start_r  <= 1'b0;
      auto_mode_r <= 1'b0;
    end
    else
    begin
      ee_req_r <= 1'b0;
      unique case (boot_r)
        switch_gid_pkg::BOOT_STRAP:
        begin
          if (settle_r != switch_gid_pkg::STRAP_SETTLE)
            settle_r <= settle_r + 1'b1;
          else if (strap == switch_gid_pkg::STRAP_BOTH_LOW)
          begin
            auto_mode_r <= 1'b1;
            boot_r      <= switch_gid_pkg::BOOT_RD0;
          end
          else
            boot_r <= switch_gid_pkg::BOOT_MAN;
        end
        switch_gid_pkg::BOOT_RD0,
        switch_gid_pkg::BOOT_RD1,
        switch_gid_pkg::BOOT_RD2:
        begin
          if (!ee_pend_r)
          begin
            ee_req_r  <= 1'b1;
            ee_pend_r <= 1'b1;
            if (boot_r == switch_gid_pkg::BOOT_RD0)
              ee_addr_r <= switch_gid_pkg::REG_FAMILY;
            else if (boot_r == switch_gid_pkg::BOOT_RD1)
              ee_addr_r <= switch_gid_pkg::REG_ID_START;
            else
              ee_addr_r <= switch_gid_pkg::REG_GCTRL0;
          end
          else if (ee_rsp.done)
          begin
            ee_pend_r <= 1'b0;
            if (ee_rsp.absent)
              boot_r <= switch_gid_pkg::BOOT_RUN;
            else if (boot_r == switch_gid_pkg::BOOT_RD0)
            begin
              ee_match_r <= (ee_rsp.data == FAMILY_CODE);
              boot_r     <= switch_gid_pkg::BOOT_RD1;
            end
            else if (boot_r == switch_gid_pkg::BOOT_RD1)
            begin
              ee_match_r <= ee_match_r &&
                (ee_rsp.data[switch_gid_pkg::ID1_CODE_MSB:
                             switch_gid_pkg::ID1_CODE_LSB] == DEVICE_CODE);
              ee_start_r <= ee_rsp.data[switch_gid_pkg::START_BIT];
              boot_r     <= switch_gid_pkg::BOOT_RD2;
            end
            else
              boot_r <= switch_gid_pkg::BOOT_RUN;
          end
        end
        switch_gid_pkg::BOOT_RUN,
        switch_gid_pkg::BOOT_MAN:
          boot_r <= boot_r;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      start_r <= 1'b0;
    else if (ee_load)
      start_r <= ee_start_r;
    else if (wr_id)
      start_r <= reg_wdata[switch_gid_pkg::START_BIT];
  end

  // reserved bits start at reset pattern
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      gc0_r <= switch_gid_pkg::GC0_RESET;
    else if (ee_load)
      gc0_r <= ee_rsp.data;
    else if (wr_gc0)
      gc0_r <= reg_wdata;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      running_r <= 1'b0;
    else
      running_r <= (boot_r == switch_gid_pkg::BOOT_RUN) ||
                   ((boot_r == switch_gid_pkg::BOOT_MAN) && start_r);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= switch_gid_pkg::ZERO_BYTE;
    else if (reg_rd)
    begin
      case (reg_addr)
        switch_gid_pkg::REG_FAMILY:   rdata_r <= FAMILY_CODE;
        switch_gid_pkg::REG_ID_START: rdata_r <= {DEVICE_CODE, REVISION,
                                                  start_r};
        switch_gid_pkg::REG_GCTRL0:   rdata_r <= gc0_r;
        default:                      rdata_r <= switch_gid_pkg::ZERO_BYTE;
      endcase
    end
    else
      rdata_r <= switch_gid_pkg::ZERO_BYTE;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      backoff_r <= 1'b0;
      pause_r   <= 1'b0;
    end
    else
    begin
      backoff_r <= gc0_r.new_backoff;
      pause_r   <= gc0_r.pass_pause;
    end
  end

  // link loss detection
  assign link_fall = |(link_d_r & ~port_link_up);
  assign fast_req  = link_fall && gc0_r.link_age;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_d_r <= '0;
      flush_r  <= 1'b0;
    end
    else
    begin
      link_d_r <= port_link_up;
      flush_r  <= link_fall;
    end
  end

  age_timer #(
    .NORMAL_AGE_US (NORMAL_AGE_US)
  ) u_age (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .fast_req    (fast_req),
    .age_tick    (age_tick),
    .fast_active (fast_age_active)
  );

  assign reg_rdata      = rdata_r;
  assign ee_rd_req      = ee_req_r;
  assign ee_rd_addr     = ee_addr_r;
  assign switch_running = running_r;
  assign new_backoff_en = backoff_r;
  assign pass_pause_en  = pause_r;
  assign flush_all      = flush_r;

  manual_start_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    boot_r == switch_gid_pkg::BOOT_MAN && $rose(start_r) |-> ##1 running_r)
    else $error("manual start did not run");
  manual_stop_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    auto_mode_r == 1'b0 && !start_r |=> !running_r)
    else $error("running without start bit");
  auto_start_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    boot_r == switch_gid_pkg::BOOT_RUN |=> running_r && auto_mode_r)
    else $error("automatic start missing");
  ee_absent_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ee_answer && ee_rsp.absent && !wr_gc0
    |=> boot_r == switch_gid_pkg::BOOT_RUN && gc0_r == $past(gc0_r))
    else $error("absent eeprom changed defaults");
  ee_load_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ee_load |=> gc0_r == $past(ee_rsp.data) ##1 running_r)
    else $error("eeprom contents not loaded");
  ee_reject_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ee_answer && !ee_match_r && !wr_gc0 && !wr_id
    |=> gc0_r == $past(gc0_r) && start_r == $past(start_r))
    else $error("mismatched eeprom loaded");
  family_read_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == switch_gid_pkg::REG_FAMILY
    |=> reg_rdata == FAMILY_CODE ##1 reg_rdata == '0 || $past(reg_rd))
    else $error("family code read wrong");
  id_read_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == switch_gid_pkg::REG_ID_START
    |=> reg_rdata[7:1] == {DEVICE_CODE, REVISION})
    else $error("device code or revision read wrong");
  backoff_sel_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_gc0 && !ee_load |-> ##2 new_backoff_en == $past(reg_wdata[7], 2))
    else $error("back-off select not applied");
  pause_pass_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_gc0 && !ee_load |-> ##2 pass_pause_en == $past(reg_wdata[3], 2))
    else $error("pause pass select not applied");
  fast_trig_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    link_fall && gc0_r.link_age |=> fast_age_active)
    else $error("link loss did not start fast age");
  no_trig_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !gc0_r.link_age && !fast_age_active |=> !fast_age_active)
    else $error("fast age started while disabled");
  unplug_flush_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    link_fall |=> flush_all)
    else $error("unplug did not flush addresses");
  start_back_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_id && !ee_load ##1 reg_rd && reg_addr == switch_gid_pkg::REG_ID_START
    |=> reg_rdata[0] == $past(reg_wdata[0], 2))
    else $error("start bit readback wrong");

endmodule

// ==== pkg/switch_gid_pkg.sv ====
// constants, types and register map of the global id and start-up bank
package switch_gid_pkg;

  // clock and timing
  localparam int CLK_FREQ_HZ       = 250_000_000;
  localparam int US_CYCLES         = CLK_FREQ_HZ / 1_000_000;
  localparam int FAST_AGE_US       = 800;
  localparam int FAST_AGE_CYCLES   = FAST_AGE_US * US_CYCLES;
  localparam int FAST_AGE_LIMIT_US = FAST_AGE_US - 2;
  localparam int NORMAL_AGE_SEC    = 200;
  localparam int NORMAL_AGE_US     = NORMAL_AGE_SEC * 1_000_000;
  localparam int AGE_CNT_W         = 28;
  localparam int US_CNT_W          = 8;
  localparam int FAST_CYC_W        = 18;

  // register offsets
  localparam logic [7:0] REG_FAMILY   = 8'h00;
  localparam logic [7:0] REG_ID_START = 8'h01;
  localparam logic [7:0] REG_GCTRL0   = 8'h02;

  // field positions
  localparam int ID1_CODE_MSB = 7;
  localparam int ID1_CODE_LSB = 4;
  localparam int ID1_REV_MSB  = 3;
  localparam int ID1_REV_LSB  = 1;
  localparam int START_BIT    = 0;

  // reset values
  localparam logic [7:0] GC0_RESET = 8'h44;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // start-up
  localparam logic [1:0] STRAP_BOTH_LOW = 2'h0;
  localparam logic [3:0] STRAP_SETTLE   = 4'h7;
  localparam int         PORT_COUNT     = 3;

  // global control zero layout
  typedef struct packed {
    logic       new_backoff;
    logic [2:0] rsvd_hi;
    logic       pass_pause;
    logic       rsvd_b2;
    logic       rsvd_b1;
    logic       link_age;
  } gc0_s;

  // eeprom byte reader answer
  typedef struct packed {
    logic       done;
    logic       absent;
    logic [7:0] data;
  } ee_rsp_s;

  // start-up sequencer
  typedef enum logic [5:0] {
    BOOT_STRAP = 6'b000001,
    BOOT_RD0   = 6'b000010,
    BOOT_RD1   = 6'b000100,
    BOOT_RD2   = 6'b001000,
    BOOT_RUN   = 6'b010000,
    BOOT_MAN   = 6'b100000
  } boot_e;

endpackage

// ==== design/strap_sync.sv ====
// three-stage synchroniser for the boot mode strap pins
`timescale 1ns/1ps
module strap_sync (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // pins and settled values
  input  wire logic [1:0] pin_in,
  output logic      [1:0] pin_stable
);

  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;
  logic [1:0] stable_r;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_bit
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_r[gi]     <= 1'b0;
          s2_r[gi]     <= 1'b0;
          s3_r[gi]     <= 1'b0;
          stable_r[gi] <= 1'b0;
        end
        else
        begin
          s1_r[gi] <= pin_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          // change counts once second and third agree
          if (s2_r[gi] == s3_r[gi])
            stable_r[gi] <= s3_r[gi];
        end
      end
    end
  endgenerate

  assign pin_stable = stable_r;

endmodule

// ==== design/age_timer.sv ====
// address table age period timer with fast age cycle
`timescale 1ns/1ps
module age_timer #(
  parameter int NORMAL_AGE_US = switch_gid_pkg::NORMAL_AGE_US
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // control
  input  wire logic fast_req,
  // status
  output logic      age_tick,
  output logic      fast_active
);

  localparam logic [switch_gid_pkg::US_CNT_W-1:0] US_LAST =
    switch_gid_pkg::US_CNT_W'(switch_gid_pkg::US_CYCLES - 1);
  localparam logic [switch_gid_pkg::AGE_CNT_W-1:0] NORM_LAST =
    switch_gid_pkg::AGE_CNT_W'(NORMAL_AGE_US - 1);
  localparam logic [switch_gid_pkg::AGE_CNT_W-1:0] FAST_LAST =
    switch_gid_pkg::AGE_CNT_W'(switch_gid_pkg::FAST_AGE_LIMIT_US);
  localparam logic [switch_gid_pkg::FAST_CYC_W-1:0] FAST_MAX =
    switch_gid_pkg::FAST_CYC_W'(switch_gid_pkg::FAST_AGE_CYCLES);

  logic [switch_gid_pkg::US_CNT_W-1:0]   us_cnt_r;
  logic [switch_gid_pkg::AGE_CNT_W-1:0]  age_cnt_r;
  logic [switch_gid_pkg::AGE_CNT_W-1:0]  age_last;
  logic [switch_gid_pkg::FAST_CYC_W-1:0] fast_cyc_r;
  logic                                  us_tick;
  logic                                  age_tick_r;
  logic                                  fast_active_r;

  assign us_tick  = (us_cnt_r == US_LAST);
  assign age_last = fast_active_r ? FAST_LAST : NORM_LAST;

  // microsecond enable divider
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      us_cnt_r <= '0;
    else if (us_tick)
      us_cnt_r <= '0;
    else
      us_cnt_r <= us_cnt_r + 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      age_cnt_r     <= '0;
      age_tick_r    <= 1'b0;
      fast_active_r <= 1'b0;
    end
    else if (fast_req)
    begin
      age_cnt_r     <= '0;
      age_tick_r    <= 1'b0;
      fast_active_r <= 1'b1;
    end
    else
    begin
      age_tick_r <= 1'b0;
      if (us_tick)
      begin
        if (age_cnt_r == age_last)
        begin
          age_cnt_r     <= '0;
          age_tick_r    <= 1'b1;
          fast_active_r <= 1'b0;
        end
        else
          age_cnt_r <= age_cnt_r + 1'b1;
      end
    end
  end

  // cycles spent in a fast cycle, for checking only
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      fast_cyc_r <= '0;
    else if (fast_req)
      fast_cyc_r <= '0;
    else if (fast_active_r)
      fast_cyc_r <= fast_cyc_r + 1'b1;
  end

  assign age_tick    = age_tick_r;
  assign fast_active = fast_active_r;

  fast_bound_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    fast_active_r |-> fast_cyc_r < FAST_MAX)
    else $error("fast age cycle too long");

  fast_end_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(fast_active_r) |-> age_tick_r && age_cnt_r == '0)
    else $error("fast age ended without age tick");

endmodule

// ==== verif/ee_model.sv ====
// configuration eeprom byte responder for the start-up sequencer
`timescale 1ns/1ps
module ee_model (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  // byte read request
  input  wire logic               ee_rd_req,
  input  wire logic [7:0]         ee_rd_addr,
  output switch_gid_pkg::ee_rsp_s ee_rsp,
  // image control
  input  wire logic               present,
  input  wire logic [3:0]         lat,
  input  wire logic [23:0]        img
);
  logic [3:0] cnt_r;
  logic [7:0] addr_r;

  // answer each request after lat cycles
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r  <= 4'h0;
      addr_r <= 8'h00;
      ee_rsp <= '0;
    end
    else
    begin
      ee_rsp.done   <= 1'b0;
      ee_rsp.absent <= 1'b0;
      ee_rsp.data   <= ~ee_rsp.data;
      if (ee_rd_req)
      begin
        cnt_r  <= lat;
        addr_r <= ee_rd_addr;
      end
      else if (cnt_r != 4'h0)
      begin
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r == 4'h1)
        begin
          ee_rsp.done   <= 1'b1;
          ee_rsp.absent <= ~present;
          ee_rsp.data   <= (addr_r < 8'h03) ?
                           img[{addr_r[1:0], 3'b000} +: 8] : 8'hFF;
        end
      end
    end
  end
endmodule

// ==== verif/test_switch_global_id_start_control.sv ====
// self-checking bench of the global id and start-up register bank
`timescale 1ns/1ps
module test_switch_global_id_start_control;
  // arbitrary identity values
  localparam logic [7:0] FAM = 8'h5A;
  localparam logic [3:0] DEV = 4'h3;
  localparam logic [2:0] REV = 3'h1;
  localparam logic [7:0] ID1 = {DEV, REV, 1'b0};
  // short normal age period for simulation
  localparam int         AGE_US  = 20;
  localparam int         AGE_GAP = AGE_US * switch_gid_pkg::US_CYCLES;

  logic                    sys_clk      = 1'b0;
  logic                    rst_n        = 1'b0;
  logic [7:0]              reg_addr     = 8'h00;
  logic [7:0]              reg_wdata    = 8'h00;
  logic                    reg_wr       = 1'b0;
  logic                    reg_rd       = 1'b0;
  logic [1:0]              strap        = 2'h1;
  logic                    ee_present   = 1'b0;
  logic [3:0]              ee_lat       = 4'h1;
  logic [23:0]             ee_img       = 24'h000000;
  logic [2:0]              port_link_up = 3'b111;
  logic [7:0]              reg_rdata;
  logic                    ee_rd_req;
  logic [7:0]              ee_rd_addr;
  switch_gid_pkg::ee_rsp_s ee_rsp;
  logic                    switch_running;
  logic                    new_backoff_en;
  logic                    pass_pause_en;
  logic                    age_tick;
  logic                    fast_age_active;
  logic                    flush_all;
  int                      miscompares = 0;
  int                      checks      = 0;

  always #2 sys_clk = ~sys_clk;

  switch_global_id_start_control #(
    .NORMAL_AGE_US (AGE_US),
    .FAMILY_CODE   (FAM),
    .DEVICE_CODE   (DEV),
    .REVISION      (REV)
  ) u_dut (
    .sys_clk              (sys_clk),
    .rst_n                (rst_n),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .boot_mode_strap_high (strap[1]),
    .boot_mode_strap_low  (strap[0]),
    .ee_rd_req            (ee_rd_req),
    .ee_rd_addr           (ee_rd_addr),
    .ee_rsp               (ee_rsp),
    .port_link_up         (port_link_up),
    .switch_running       (switch_running),
    .new_backoff_en       (new_backoff_en),
    .pass_pause_en        (pass_pause_en),
    .age_tick             (age_tick),
    .fast_age_active      (fast_age_active),
    .flush_all            (flush_all)
  );

  ee_model u_ee (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .ee_rd_req  (ee_rd_req),
    .ee_rd_addr (ee_rd_addr),
    .ee_rsp     (ee_rsp),
    .present    (ee_present),
    .lat        (ee_lat),
    .img        (ee_img)
  );

  task automatic test_done();
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reset_dut(input logic [1:0] s, input logic pres,
                           input logic [3:0] lat, input logic [23:0] img);
    @(posedge sys_clk);
    rst_n      <= 1'b0;
    strap      <= s;
    ee_present <= pres;
    ee_lat     <= lat;
    ee_img     <= img;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  task automatic bit_chk(input string what, input logic exp,
                         input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic cnt_chk(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // write then read with no gap between the strobes
  task automatic wr_rd_chk(input string what, input logic [7:0] a,
                           input logic [7:0] d, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  task automatic wait_run();
    int n;
    n = 0;
    while (switch_running !== 1'b1 && n < 200)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (switch_running !== 1'b1)
    begin
      bit_chk("switch running", 1'b1, switch_running);
      test_done();
    end
  endtask

  task automatic link_drop(input logic exp_fast);
    int pulses;
    pulses = 0;
    @(posedge sys_clk);
    port_link_up <= 3'b101;
    repeat (4)
    begin
      @(posedge sys_clk);
      #1;
      if (flush_all === 1'b1)
        pulses++;
    end
    chk("flush pulses", 8'h01, 8'(pulses));
    bit_chk("fast age active", exp_fast, fast_age_active);
    @(posedge sys_clk);
    port_link_up <= 3'b111;
  endtask

  task automatic t_regs();
    reset_dut(2'h3, 1'b0, 4'h1, 24'h000000);
    rd_chk("family", 8'h00, FAM);
    rd_chk("id and start", 8'h01, ID1);
    rd_chk("control reset", 8'h02, 8'h44);
    rd_chk("unmapped", 8'h10, 8'h00);
    wr(8'h00, 8'hFF);
    rd_chk("family kept", 8'h00, FAM);
    wr(8'h01, 8'hFF);
    rd_chk("start readback", 8'h01, ID1 | 8'h01);
    wr(8'h02, 8'hCC);
    repeat (3) @(posedge sys_clk);
    #1;
    bit_chk("backoff on", 1'b1, new_backoff_en);
    bit_chk("pause on", 1'b1, pass_pause_en);
    rd_chk("control", 8'h02, 8'hCC);
    wr(8'h02, 8'h44);
    repeat (3) @(posedge sys_clk);
    #1;
    bit_chk("backoff off", 1'b0, new_backoff_en);
    bit_chk("pause off", 1'b0, pass_pause_en);
  endtask

  task automatic t_manual();
    for (int m = 1; m < 4; m++)
    begin
      reset_dut(2'(m), 1'b1, 4'h1, 24'h000000);
      repeat (20) @(posedge sys_clk);
      #1;
      bit_chk("held stopped", 1'b0, switch_running);
      wr_rd_chk("start echo", 8'h01, 8'h01, ID1 | 8'h01);
      repeat (3) @(posedge sys_clk);
      #1;
      bit_chk("started", 1'b1, switch_running);
      rd_chk("start set", 8'h01, ID1 | 8'h01);
      wr(8'h01, 8'h00);
      repeat (3) @(posedge sys_clk);
      #1;
      bit_chk("stopped", 1'b0, switch_running);
    end
  endtask

  task automatic t_auto();
    reset_dut(2'h0, 1'b0, 4'h2, 24'h000000);
    wait_run();
    rd_chk("defaults kept", 8'h02, 8'h44);
    link_drop(1'b0);
    reset_dut(2'h0, 1'b1, 4'h3, {8'hC5, DEV, 4'h1, FAM});
    wait_run();
    rd_chk("image loaded", 8'h02, 8'hC5);
    rd_chk("start loaded", 8'h01, ID1 | 8'h01);
    bit_chk("backoff loaded", 1'b1, new_backoff_en);
    bit_chk("pause loaded", 1'b0, pass_pause_en);
    link_drop(1'b1);
    reset_dut(2'h0, 1'b1, 4'h1, {8'hC5, 4'h9, 4'h1, FAM});
    wait_run();
    rd_chk("code mismatch", 8'h02, 8'h44);
    reset_dut(2'h0, 1'b1, 4'h1, {8'hC5, DEV, 4'h1, ~FAM});
    wait_run();
    rd_chk("family mismatch", 8'h02, 8'h44);
    rd_chk("start not loaded", 8'h01, ID1);
  endtask

  task automatic t_age();
    int n;
    int gap;
    n   = 0;
    gap = 1;
    reset_dut(2'h3, 1'b0, 4'h1, 24'h000000);
    while (age_tick !== 1'b1 && n < 2 * AGE_GAP)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    bit_chk("age tick", 1'b1, age_tick);
    @(posedge sys_clk);
    #1;
    while (age_tick !== 1'b1 && gap < 2 * AGE_GAP)
    begin
      @(posedge sys_clk);
      #1;
      gap++;
    end
    cnt_chk("age period", 32'(AGE_GAP), 32'(gap));
  endtask

  initial
  begin
    t_regs();
    t_manual();
    t_auto();
    t_age();
    test_done();
  end
endmodule
